// ### hdl/ctr_pkg.sv
// shared sizes, field positions and reset values of the tag-compare store
package ctr_pkg;
  localparam int              CTR_ADDR_W    = 14;      // 16K entries
  localparam int              CTR_TAG_W     = 12;      // stored tag width
  localparam int              CTR_FLAG_W    = 3;       // status bits per entry
  localparam int              CTR_VALID_BIT = 0;       // valid / first generic bit
  localparam int              CTR_DIRTY_BIT = 1;       // dirty / second generic bit
  localparam int              CTR_WTHRU_BIT = 2;       // write-through / third bit
  localparam logic [2:0]      CTR_FLAG_RST  = 3'h0;    // cleared status value
  localparam logic [11:0]     CTR_TAG_RST   = 12'h000; // tag output idle value
endpackage : ctr_pkg

// ### hdl/ctr_tag_ram.sv
// cache-tag store with tag comparator, status bits and burst-ready generation
// Functional notes
// - 16K entries, each a 12-bit tag plus three status bits.
// - tag pins are inputs on write and compare, outputs on tag read.
// - hit goes high when presented tag equals the stored tag.
// - in dedicated mode the stored valid bit qualifies hit; invalid entries never hit there.
// - reads and compare combinational; writes and status reset on rising clock.
// - separate write enables for tag field and status field.
// - separate output enables for tag pins, status pins and burst ready.
// - status reset low at clock edge clears status of every entry.
// - select low: status bits mean valid, dirty, write-through internally.
// - select high: status bits are plain user storage, no meaning.
// - burst ready built from hit, valid, write-through, write/read and extra inputs.
// - both chip selects must be asserted for the device to respond, except to the status reset, which clears regardless.
// - standby request puts the device in low-power standby.
// - during a status write, status inputs pass through to enabled outputs.
// - dedicated mode: stored valid low forces hit low.
`timescale 1ns/1ps
module ctr_tag_ram
  import ctr_pkg::*;
#(
  parameter int ADDR_W = CTR_ADDR_W,
  parameter int TAG_W  = CTR_TAG_W
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              select_low_active_n,
  input  wire logic              select_high_active,
  input  wire logic              tag_write_enable_n,
  input  wire logic              flag_write_enable_n,
  input  wire logic              tag_output_enable_n,
  input  wire logic              flag_output_enable_n,
  input  wire logic              status_reset_n,
  input  wire logic              standby_request_n,
  input  wire logic              flag_meaning_select,
  input  wire logic              proc_write_not_read,
  input  wire logic              valid_flag_in,
  input  wire logic              dirty_flag_in,
  input  wire logic              writethrough_flag_in,
  input  wire logic              burst_ready_force_high,
  input  wire logic              burst_ready_output_enable_n,
  input  wire logic              burst_ready_extra_in_n,
  input  wire logic [TAG_W-1:0]  tag_bus_in,
  output logic [TAG_W-1:0]       tag_bus_out,
  output logic                   tag_bus_oe,
  output logic                   valid_flag_out,
  output logic                   dirty_flag_out,
  output logic                   writethrough_flag_out,
  output logic                   flag_out_oe,
  output logic                   match_out,
  output logic                   match_oe,
  output logic                   burst_ready_out_n,
  output logic                   burst_ready_oe,
  output logic                   standby_state
);

  localparam int DEPTH = 1 << ADDR_W;

  // limitation: reads and the compare must follow address and tag pins within
  // the same cycle, so the pin outputs are decoded from the array, not held in
  // flip-flops; a registered copy would answer one cycle late and the cache
  // controller would miss its window. the shared tag pins are split into an
  // input, an output and an enable so that the pad ring can build the driver.

  // why the burst-ready pin holds its level; one decode drives the pin so
  // the priority order is written down in a single place
  typedef enum {
    BURST_EXTERNAL,
    BURST_BLOCKED,
    BURST_INVALID,
    BURST_MISS,
    BURST_WTHRU_WRITE,
    BURST_READY
  } ctr_burst_cause_e;

  logic [TAG_W-1:0]      tag_mem  [DEPTH];
  logic [CTR_FLAG_W-1:0] flag_mem [DEPTH];

  // select and access decode
  logic                  selected;
  logic                  active;
  logic                  resetting;
  logic                  dedicated;
  logic                  tag_wr;
  logic                  flag_wr;

  // read side of the addressed entry
  logic [TAG_W-1:0]      stored_tag;
  logic [CTR_FLAG_W-1:0] stored_flags;
  logic [CTR_FLAG_W-1:0] write_flags;
  logic [CTR_FLAG_W-1:0] shown_flags;

  // compare and burst-ready decision
  logic                  tag_equal;
  logic                  busy;
  logic                  invalid_entry;
  logic                  hit;
  ctr_burst_cause_e      cause;

  // any operation that owns the pins or the array spoils the compare;
  // shared by the hit mask and the burst-ready blocking row
  function automatic logic pins_busy(
    input logic clearing,
    input logic tag_we_n,
    input logic flag_we_n,
    input logic tag_oe_n
  );
    pins_busy = clearing || !tag_we_n || !flag_we_n || !tag_oe_n;
  endfunction : pins_busy

  // an entry is invalid only while the bits carry their dedicated meaning;
  // in generic mode the valid position is plain user storage
  function automatic logic entry_invalid(
    input logic                  dedicated_mode,
    input logic [CTR_FLAG_W-1:0] flags
  );
    entry_invalid = dedicated_mode && !flags[CTR_VALID_BIT];
  endfunction : entry_invalid

  // status input pins placed at their storage positions
  function automatic logic [CTR_FLAG_W-1:0] pack_flags(
    input logic valid_bit,
    input logic dirty_bit,
    input logic wthru_bit
  );
    logic [CTR_FLAG_W-1:0] word;
    word                = CTR_FLAG_RST;
    word[CTR_VALID_BIT] = valid_bit;
    word[CTR_DIRTY_BIT] = dirty_bit;
    word[CTR_WTHRU_BIT] = wthru_bit;
    pack_flags          = word;
  endfunction : pack_flags

  // burst-ready priority: external input first, then anything that blocks
  // a compare, then the stored status and the compare itself
  function automatic ctr_burst_cause_e burst_cause(
    input logic                  extra_n,
    input logic                  blocked,
    input logic                  dedicated_mode,
    input logic [CTR_FLAG_W-1:0] flags,
    input logic                  hit_now,
    input logic                  write_cycle
  );
    if (!extra_n) begin
      burst_cause = BURST_EXTERNAL;
    end else if (blocked) begin
      burst_cause = BURST_BLOCKED;
    end else if (entry_invalid(dedicated_mode, flags)) begin
      burst_cause = BURST_INVALID;
    end else if (!hit_now) begin
      burst_cause = BURST_MISS;
    // a write-through hit on a write must still go out to memory
    end else if (dedicated_mode && flags[CTR_WTHRU_BIT] && write_cycle) begin
      burst_cause = BURST_WTHRU_WRITE;
    end else begin
      burst_cause = BURST_READY;
    end
  endfunction : burst_cause

  assign selected  = !select_low_active_n && select_high_active;
  // standby deselects all; only the pins are idled, the array keeps
  // its contents, so nothing has to be rewritten on wake-up
  assign active    = selected && standby_request_n;
  // the clear is a level sampled at the edge, not a pulse
  assign resetting = !status_reset_n;
  assign dedicated = !flag_meaning_select;

  // independent field writes; a tag write with tag drivers on is refused
  // so that the pins never fight the controller
  assign tag_wr  = active && !resetting && !tag_write_enable_n && tag_output_enable_n;
  assign flag_wr = active && !resetting && !flag_write_enable_n;

  // asynchronous read of the addressed entry
  assign stored_tag   = tag_mem[addr];
  assign stored_flags = flag_mem[addr];
  assign tag_equal    = (tag_bus_in == stored_tag);

  // shared decodes used by the hit path, the status pins and the array write
  assign busy          = pins_busy(resetting, tag_write_enable_n, flag_write_enable_n,
                                   tag_output_enable_n);
  assign invalid_entry = entry_invalid(dedicated, stored_flags);
  assign write_flags   = pack_flags(valid_flag_in, dirty_flag_in, writethrough_flag_in);

  // hit qualification; the comparison is meaningless while the pins are busy
  always_comb begin
    // writes and tag reads mask the hit
    if (busy) begin
      hit = 1'b0;
    end else if (invalid_entry) begin
      hit = 1'b0;
    // valid qualifies, generic mode ignores it
    end else begin
      hit = tag_equal;
    end
  end

  // written values pass straight through; reset shows cleared bits
  always_comb begin
    if (resetting) begin
      shown_flags = CTR_FLAG_RST;
    end else if (!flag_write_enable_n) begin
      shown_flags = write_flags;
    end else begin
      shown_flags = stored_flags;
    end
  end

  // tag array write; no reset because the array has no defined content
  always_ff @(posedge core_clk) begin
    if (tag_wr) begin
      tag_mem[addr] <= tag_bus_in;
    end
  end

  // status array: global clear wins over any write, selects do not matter;
  // reaching every entry in one edge costs a wide clear net
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        flag_mem[i] <= CTR_FLAG_RST;
      end
    end else if (resetting) begin
      for (int i = 0; i < DEPTH; i++) begin
        flag_mem[i] <= CTR_FLAG_RST;
      end
    end else if (flag_wr) begin
      flag_mem[addr] <= write_flags;
    end
  end

  // tag pins driven only on a tag read
  always_comb begin
    tag_bus_oe  = active && !resetting && !tag_output_enable_n && tag_write_enable_n;
    tag_bus_out = tag_bus_oe ? stored_tag : CTR_TAG_RST;
  end

  // status pins have their own enable
  always_comb begin
    flag_out_oe           = active && !flag_output_enable_n;
    valid_flag_out        = shown_flags[CTR_VALID_BIT];
    dirty_flag_out        = shown_flags[CTR_DIRTY_BIT];
    writethrough_flag_out = shown_flags[CTR_WTHRU_BIT];
  end

  // hit pin is enabled whenever the device is selected and awake
  always_comb begin
    match_oe  = active;
    match_out = hit;
  end

  // standby is reported straight from the request pin
  always_comb begin
    standby_state = !standby_request_n;
  end

  // burst-ready cause; force high joins the blocking row
  always_comb begin
    cause = burst_cause(burst_ready_extra_in_n, busy || burst_ready_force_high, dedicated,
                        stored_flags, hit, proc_write_not_read);
  end

  // burst-ready pin has its own enable
  always_comb begin
    burst_ready_oe = active && !burst_ready_output_enable_n;
  end

  // burst ready, active low; high means not ready
  always_comb begin
    unique case (cause)
      // the external ready input overrides every other row
      BURST_EXTERNAL: begin
        burst_ready_out_n = 1'b0;
      end
      BURST_BLOCKED: begin
        burst_ready_out_n = 1'b1;
      end
      BURST_INVALID: begin
        burst_ready_out_n = 1'b1;
      end
      BURST_MISS: begin
        burst_ready_out_n = 1'b1;
      end
      BURST_WTHRU_WRITE: begin
        burst_ready_out_n = 1'b1;
      end
      BURST_READY: begin
        burst_ready_out_n = 1'b0;
      end
    endcase
  end

endmodule : ctr_tag_ram

// ### tb/ctr_tag_ram_properties.sv
// assertion checker for the tag-compare store
`timescale 1ns/1ps
module ctr_tag_ram_properties (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic select_low_active_n,
  input wire logic select_high_active,
  input wire logic standby_request_n,
  input wire logic tag_write_enable_n,
  input wire logic flag_write_enable_n,
  input wire logic tag_output_enable_n,
  input wire logic flag_output_enable_n,
  input wire logic status_reset_n,
  input wire logic flag_meaning_select,
  input wire logic valid_flag_out,
  input wire logic match_out,
  input wire logic match_oe,
  input wire logic tag_bus_oe,
  input wire logic standby_state
);
  // selected and awake; a status read shows the stored valid bit
  wire cs_on = !select_low_active_n && select_high_active;
  wire sel   = cs_on && standby_request_n;
  wire busy  = !tag_write_enable_n || !flag_write_enable_n || !tag_output_enable_n;
  wire st_rd = sel && flag_write_enable_n && !flag_output_enable_n;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_blk; busy |-> !match_out; endproperty
  a_blk: assert property (p_blk) else $error("hit not held low");
  property p_inv; st_rd && !flag_meaning_select && !valid_flag_out |-> !match_out; endproperty
  a_inv: assert property (p_inv) else $error("invalid entry hit");
  property p_clr; sel && !status_reset_n ##1 st_rd |-> !valid_flag_out; endproperty
  a_clr: assert property (p_clr) else $error("status not cleared");
  property p_srm; !status_reset_n |-> !match_out; endproperty
  a_srm: assert property (p_srm) else $error("hit during clear");
  property p_dsl; !cs_on |-> !match_oe && !tag_bus_oe; endproperty
  a_dsl: assert property (p_dsl) else $error("drives while deselected");
  property p_sby; !standby_request_n |-> standby_state && !match_oe && !tag_bus_oe; endproperty
  a_sby: assert property (p_sby) else $error("standby not honoured");
  property p_toe; tag_bus_oe |-> !tag_output_enable_n; endproperty
  a_toe: assert property (p_toe) else $error("tag pins driven unasked");
  property p_moe; sel |-> match_oe; endproperty
  a_moe: assert property (p_moe) else $error("hit output not enabled");
endmodule : ctr_tag_ram_properties

// ### tb/ctr_host.sv
// host model that resolves the shared tag pins
`timescale 1ns/1ps
module ctr_host
  import ctr_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 host_en,
  input  wire logic [CTR_TAG_W-1:0] host_tag,
  input  wire logic                 tag_bus_oe,
  input  wire logic [CTR_TAG_W-1:0] tag_bus_out,
  output logic      [CTR_TAG_W-1:0] tag_bus_in
);
  logic [CTR_TAG_W-1:0] junk = 12'hA5A;
  // released pins float, so show a changing pattern rather than a held value
  always @(posedge core_clk) junk <= ~junk;
  assign tag_bus_in = tag_bus_oe ? tag_bus_out : (host_en ? host_tag : junk);
endmodule : ctr_host

// ### tb/testbench.sv
// self-checking bench for the tag-compare store
`timescale 1ns/1ps
module testbench;
  // selects active, standby and clear released
  logic core_clk = 1'h0, reset_n = 1'h0, select_low_active_n = 1'h0, select_high_active = 1'h1;
  logic standby_request_n = 1'h1, status_reset_n = 1'h1, flag_meaning_select = 1'h1;
  logic tag_write_enable_n = 1'h1, flag_write_enable_n = 1'h1, tag_output_enable_n = 1'h1;
  logic flag_output_enable_n = 1'h0, burst_ready_output_enable_n = 1'h0, host_en = 1'h1;
  logic burst_ready_extra_in_n = 1'h1, burst_ready_force_high = 1'h0, proc_write_not_read = 1'h0;
  logic valid_flag_in = 1'h0, dirty_flag_in = 1'h0, writethrough_flag_in = 1'h0;
  logic [13:0] addr = 14'h3FFF;
  logic [11:0] host_tag = 12'hABC, tag_bus_in, tag_bus_out;
  logic tag_bus_oe, valid_flag_out, dirty_flag_out, writethrough_flag_out, flag_out_oe;
  logic match_out, match_oe, burst_ready_out_n, burst_ready_oe, standby_state;
  int miscompares = 0, n_tests = 0;
  ctr_tag_ram i_dut (.*);
  ctr_host i_host (.*);
  // 40 MHz system clock
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // top address, generic mode: stored tag hits although valid is clear
  task automatic t_tags();
    @(posedge core_clk);
    tag_write_enable_n <= 1'h0;
    @(posedge core_clk);
    tag_write_enable_n <= 1'h1;
    #1 chk(match_out, 1'h1);
    @(posedge core_clk);
    host_tag <= 12'hABD;
    #1 chk(match_out, 1'h0);
    @(posedge core_clk);
    host_en <= 1'h0;
    tag_output_enable_n <= 1'h0;
    #1 chk(tag_bus_out, 12'hABC);
    chk(match_out, 1'h0);
  endtask : t_tags
  // dedicated mode: status write passes through, tag left intact
  task automatic t_flags();
    @(posedge core_clk);
    host_en <= 1'h1;
    tag_output_enable_n <= 1'h1;
    host_tag <= 12'hABC;
    flag_meaning_select <= 1'h0;
    {writethrough_flag_in, valid_flag_in} <= 2'h3;
    flag_write_enable_n <= 1'h0;
    #1 chk({writethrough_flag_out, dirty_flag_out, valid_flag_out}, 3'h5);
    @(posedge core_clk);
    flag_write_enable_n <= 1'h1;
    #1 chk(match_out, 1'h1);
  endtask : t_flags
  // global clear, then burst ready from the extra input
  task automatic t_clear();
    @(posedge core_clk);
    status_reset_n <= 1'h0;
    @(posedge core_clk);
    status_reset_n <= 1'h1;
    #1 chk(valid_flag_out, 1'h0);
    chk(match_out, 1'h0);
    chk(burst_ready_out_n, 1'h1);
    @(posedge core_clk);
    burst_ready_extra_in_n <= 1'h0;
    #1 chk(burst_ready_out_n, 1'h0);
  endtask : t_clear
  // dedicated mode: burst ready from a valid hit, write-through write, force high
  task automatic t_burst();
    @(posedge core_clk);
    burst_ready_extra_in_n <= 1'h1;
    flag_write_enable_n <= 1'h0;
    @(posedge core_clk);
    flag_write_enable_n <= 1'h1;
    #1 chk(burst_ready_out_n, 1'h0);
    chk(burst_ready_oe, 1'h1);
    @(posedge core_clk);
    proc_write_not_read <= 1'h1;
    #1 chk(burst_ready_out_n, 1'h1);
    @(posedge core_clk);
    proc_write_not_read <= 1'h0;
    burst_ready_force_high <= 1'h1;
    #1 chk(burst_ready_out_n, 1'h1);
    @(posedge core_clk);
    burst_ready_force_high <= 1'h0;
    burst_ready_output_enable_n <= 1'h1;
    flag_output_enable_n <= 1'h1;
    #1 chk(burst_ready_oe, 1'h0);
    chk(flag_out_oe, 1'h0);
    chk(burst_ready_out_n, 1'h0);
  endtask : t_burst
  // standby, then one select dropped
  task automatic t_idle();
    @(posedge core_clk);
    standby_request_n <= 1'h0;
    #1 chk(standby_state, 1'h1);
    @(posedge core_clk);
    standby_request_n <= 1'h1;
    select_high_active <= 1'h0;
    #1 chk(match_oe, 1'h0);
  endtask : t_idle
  task automatic test_done();
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'h1;
    t_tags();
    t_flags();
    t_clear();
    t_burst();
    t_idle();
    test_done();
  end
  // watchdog: the tests need under 40 cycles
  initial begin
    #5000;
    miscompares++;
    test_done();
  end
endmodule : testbench
bind ctr_tag_ram ctr_tag_ram_properties i_props (.*);
